// ===== flash_cmd_pkg.sv
// constants and types for the serial flash reset and status-write command logic
// assumes a host that also drives the serial clock while chip select is high, so the line mode can sync
package flash_cmd_pkg;
  // line-count codes: number of data lines is 1 << code
  localparam logic [1:0] LINES_1 = 2'h0;
  localparam logic [1:0] LINES_2 = 2'h1;
  localparam logic [1:0] LINES_4 = 2'h2;
  // opcodes
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_SFDP = 8'h5A;
  localparam logic [7:0] OP_QREAD = 8'hEB;
  // continuous quad read mode byte handling
  localparam logic [3:0] CONT_MODE_NIB = 4'hA;
  localparam logic [7:0] MODE_EXIT = 8'h00;
  localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
  // phase lengths in bits or clocks
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] DUMMY_CLKS = 6'h08;
  localparam logic [5:0] NEVER = 6'h3F;
  // discovery dword 16 fields and location
  localparam logic [7:0] ENTER_4B_FIELD = 8'h80;
  localparam logic [9:0] EXIT_4B_FIELD = 10'h300;
  localparam logic [5:0] SOFT_RST_FIELD = 6'h30;
  localparam logic [0:0] DW16_RFU = 1'h1;
  localparam logic [6:0] SR1_WREN_FIELD = 7'h68;
  localparam logic [31:0] SFDP_DW16 = {ENTER_4B_FIELD, EXIT_4B_FIELD, SOFT_RST_FIELD, DW16_RFU, SR1_WREN_FIELD};
  localparam logic [23:0] DW16_REL_ADDR = 24'h00006C;
  localparam logic [7:0] SFDP_BLANK = 8'hFF;
  localparam logic [7:0] SR1_RESET = 8'h00;

  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DIN, ST_DOUT, ST_IGNORE} phase_t;

  typedef struct packed {
    logic nonvol;
    logic [7:0] data;
  } sr_wr_t;
endpackage

// ===== sync_2ff.sv
// two flip-flop level synchroniser
// assumes each bit is a level or a toggle, not a multi-bit word in motion
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d_in;
      q_reg <= meta_reg;
    end
  end

  assign q_out = q_reg;
endmodule // sync_2ff

// ===== flash_cmd_ctrl.sv
// serial flash command logic: soft reset pair, status-1 write enables,
// continuous quad read exit, discovery dword 16
// assumes the serial clock also runs while chip select is high, so the line mode can sync
// Functional notes
// - discovery bytes 6C-6F return 80_C0_30_E8
// - four-byte entry field reads unsupported pattern
// - four-byte exit field bits 23:14 unsupported
// - reset only on enable then reset pair
// - reset pair accepted on 1/2/4 lines
// - status 1 starts from stored value
// - write enable allows non-volatile status write
// - volatile enable writes overriding volatile copy
// - mode byte zero ends continuous read
// - eight all-ones clocks end continuous read
module flash_cmd_ctrl #(
  parameter logic [7:0] NV_SR1_INIT = flash_cmd_pkg::SR1_RESET,
  parameter logic [23:0] BFPT_BASE = 24'h000000
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  input wire logic [1:0] line_mode_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  output logic [7:0] status1_out,
  output logic vol_active_out,
  output logic soft_reset_out
);
  function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] io, input logic [1:0] lc);
    logic [31:0] r;
    r = {sh[30:0], io[0]};
    if (lc == flash_cmd_pkg::LINES_2) r = {sh[29:0], io[1:0]};
    if (lc == flash_cmd_pkg::LINES_4) r = {sh[27:0], io};
    return r;
  endfunction

  function automatic logic [7:0] sfdp_byte(input logic [23:0] rel);
    logic [7:0] r;
    r = flash_cmd_pkg::SFDP_BLANK;
    if (rel[23:2] == flash_cmd_pkg::DW16_REL_ADDR[23:2]) r = flash_cmd_pkg::SFDP_DW16[{rel[1:0], 3'h0} +: 8];
    return r;
  endfunction

  // link domain
  logic [1:0] mode_s;
  flash_cmd_pkg::phase_t phase_reg, phase_next, ph;
  logic [5:0] cnt_reg, cnt_next, need;
  logic [31:0] sh_reg, sh_next;
  logic [7:0] op_reg, op_next, out_byte_reg, out_byte_next;
  logic [23:0] addr_reg, addr_next, rel_addr;
  logic quad_reg, quad_next, started_reg, last;
  logic [1:0] lc;
  logic wel_reg, wel_next, vwen_reg, vwen_next, rst_en_reg, rst_en_next, cont_reg, cont_next;
  logic wr_tgl_reg, wr_tgl_next, rst_tgl_reg, rst_tgl_next;
  flash_cmd_pkg::sr_wr_t sr_wr_reg, sr_wr_next;
  logic [7:0] tmp;
  logic [3:0] drv, oe;
  logic [3:0] io_out_reg, io_oe_reg;

  sync_2ff #(.W(2)) u_mode_sync (
    .clk_in(sclk_in),
    .rst_n_in(rst_n_in),
    .d_in(line_mode_in),
    .q_out(mode_s)
  );

  always_comb begin
    ph = !started_reg ? (cont_reg ? flash_cmd_pkg::ST_ADDR : flash_cmd_pkg::ST_CMD) : phase_reg;
    lc = (!started_reg ? cont_reg : quad_reg) ? flash_cmd_pkg::LINES_4 : mode_s;
    rel_addr = addr_reg - BFPT_BASE;
    unique case (ph)
      flash_cmd_pkg::ST_ADDR: need = flash_cmd_pkg::ADDR_BITS >> lc;
      flash_cmd_pkg::ST_DUMMY: need = flash_cmd_pkg::DUMMY_CLKS;
      flash_cmd_pkg::ST_IGNORE: need = flash_cmd_pkg::NEVER;
      default: need = flash_cmd_pkg::CMD_BITS >> lc;
    endcase
    last = (cnt_reg == need - 6'h01);
    sh_next = shift_in(sh_reg, io_in, lc);
    cnt_next = last ? 6'h00 : ((ph == flash_cmd_pkg::ST_IGNORE) ? cnt_reg : cnt_reg + 6'h01);
    phase_next = ph;
    quad_next = !started_reg ? cont_reg : quad_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    out_byte_next = out_byte_reg;
    wel_next = wel_reg;
    vwen_next = vwen_reg;
    rst_en_next = rst_en_reg;
    cont_next = cont_reg;
    wr_tgl_next = wr_tgl_reg;
    rst_tgl_next = rst_tgl_reg;
    sr_wr_next = sr_wr_reg;
    if (last) begin
      unique case (ph)
        flash_cmd_pkg::ST_CMD: begin
          op_next = sh_next[7:0];
          phase_next = flash_cmd_pkg::ST_IGNORE;
          // enable kept only up to next opcode
          rst_en_next = (sh_next[7:0] == flash_cmd_pkg::OP_RST_EN);
          // reset fires on enable then reset
          if (sh_next[7:0] == flash_cmd_pkg::OP_RST && rst_en_reg) begin
            rst_tgl_next = !rst_tgl_reg;
            wel_next = 1'b0;
            vwen_next = 1'b0;
            cont_next = 1'b0;
          end
          if (sh_next[7:0] == flash_cmd_pkg::OP_WREN) wel_next = 1'b1;
          if (sh_next[7:0] == flash_cmd_pkg::OP_VWREN) vwen_next = 1'b1;
          if (sh_next[7:0] == flash_cmd_pkg::OP_WRSR && (wel_reg || vwen_reg)) phase_next = flash_cmd_pkg::ST_DIN;
          if (sh_next[7:0] == flash_cmd_pkg::OP_SFDP) phase_next = flash_cmd_pkg::ST_ADDR;
          if (sh_next[7:0] == flash_cmd_pkg::OP_QREAD) begin
            phase_next = flash_cmd_pkg::ST_ADDR;
            quad_next = 1'b1;
          end
        end
        flash_cmd_pkg::ST_ADDR: begin
          addr_next = sh_next[23:0];
          phase_next = (op_reg == flash_cmd_pkg::OP_SFDP) ? flash_cmd_pkg::ST_DUMMY : flash_cmd_pkg::ST_MODE;
        end
        flash_cmd_pkg::ST_MODE: begin
          // only an Ax mode byte keeps the mode
          cont_next = (sh_next[7:4] == flash_cmd_pkg::CONT_MODE_NIB);
          if (sh_next == flash_cmd_pkg::ALL_ONES) cont_next = 1'b0;
          phase_next = flash_cmd_pkg::ST_IGNORE;
        end
        flash_cmd_pkg::ST_DUMMY: begin
          phase_next = flash_cmd_pkg::ST_DOUT;
          out_byte_next = sfdp_byte(rel_addr);
        end
        flash_cmd_pkg::ST_DOUT: begin
          addr_next = addr_reg + 24'h000001;
          out_byte_next = sfdp_byte(rel_addr + 24'h000001);
        end
        flash_cmd_pkg::ST_DIN: begin
          sr_wr_next.nonvol = !vwen_reg;
          sr_wr_next.data = sh_next[7:0];
          wr_tgl_next = !wr_tgl_reg;
          wel_next = 1'b0;
          vwen_next = 1'b0;
          phase_next = flash_cmd_pkg::ST_IGNORE;
        end
        flash_cmd_pkg::ST_IGNORE: phase_next = flash_cmd_pkg::ST_IGNORE;
      endcase
    end
    tmp = out_byte_reg << ({2'h0, cnt_reg[3:0]} << lc);
    unique case (lc)
      flash_cmd_pkg::LINES_4: drv = tmp[7:4];
      flash_cmd_pkg::LINES_2: drv = {2'h0, tmp[7:6]};
      default: drv = {2'h0, tmp[7], 1'b0};
    endcase
    oe = 4'h0;
    if (ph == flash_cmd_pkg::ST_DOUT) begin
      unique case (lc)
        flash_cmd_pkg::LINES_4: oe = 4'hF;
        flash_cmd_pkg::LINES_2: oe = 4'h3;
        default: oe = 4'h2;
      endcase
    end
  end

  // frame state, cleared whenever chip select is high
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      phase_reg <= flash_cmd_pkg::ST_CMD;
      cnt_reg <= 6'h00;
      sh_reg <= 32'h00000000;
      op_reg <= 8'h00;
      addr_reg <= 24'h000000;
      out_byte_reg <= 8'h00;
      quad_reg <= 1'b0;
      started_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      out_byte_reg <= out_byte_next;
      quad_reg <= quad_next;
      started_reg <= 1'b1;
    end
  end

  // state kept across frames
  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wel_reg <= 1'b0;
      vwen_reg <= 1'b0;
      rst_en_reg <= 1'b0;
      cont_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
      rst_tgl_reg <= 1'b0;
      sr_wr_reg <= '0;
    end else begin
      wel_reg <= wel_next;
      vwen_reg <= vwen_next;
      rst_en_reg <= rst_en_next;
      cont_reg <= cont_next;
      wr_tgl_reg <= wr_tgl_next;
      rst_tgl_reg <= rst_tgl_next;
      sr_wr_reg <= sr_wr_next;
    end
  end

  // data out changes on the falling edge
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      io_out_reg <= 4'h0;
      io_oe_reg <= 4'h0;
    end else begin
      io_out_reg <= drv;
      io_oe_reg <= oe;
    end
  end

  // core domain
  logic [1:0] tgl_s;
  logic [1:0] tgl_prev_reg;
  logic wr_edge, rst_edge;
  logic [7:0] nv_reg, nv_next, vol_reg, vol_next, status_reg, status_next;
  logic vol_act_reg, vol_act_next, soft_reg;

  sync_2ff #(.W(2)) u_tgl_sync (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .d_in({wr_tgl_reg, rst_tgl_reg}),
    .q_out(tgl_s)
  );

  always_comb begin
    wr_edge = tgl_s[1] ^ tgl_prev_reg[1];
    rst_edge = tgl_s[0] ^ tgl_prev_reg[0];
    nv_next = nv_reg;
    vol_next = vol_reg;
    vol_act_next = vol_act_reg;
    if (wr_edge) begin
      if (sr_wr_reg.nonvol) nv_next = sr_wr_reg.data;
      else begin
        vol_next = sr_wr_reg.data;
        vol_act_next = 1'b1;
      end
    end
    status_next = vol_act_next ? vol_next : nv_next;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgl_prev_reg <= 2'h0;
      nv_reg <= NV_SR1_INIT;
      vol_reg <= flash_cmd_pkg::SR1_RESET;
      vol_act_reg <= 1'b0;
      status_reg <= NV_SR1_INIT;
      soft_reg <= 1'b0;
    end else begin
      tgl_prev_reg <= tgl_s;
      nv_reg <= nv_next;
      vol_reg <= vol_next;
      vol_act_reg <= vol_act_next;
      status_reg <= status_next;
      soft_reg <= rst_edge;
    end
  end

  assign io_out = io_out_reg;
  assign io_oe_out = io_oe_reg;
  assign status1_out = status_reg;
  assign vol_active_out = vol_act_reg;
  assign soft_reset_out = soft_reg;

  property p_dw16_bytes;
    @(posedge sclk_in) disable iff (cs_n_in || !rst_n_in)
      (ph == flash_cmd_pkg::ST_DOUT && rel_addr[23:2] == 22'h00001B) |-> out_byte_reg == flash_cmd_pkg::SFDP_DW16[{rel_addr[1:0], 3'h0} +: 8];
  endproperty
  a_dw16_bytes: assert property (p_dw16_bytes) else $error("dword 16 byte wrong");
  property p_enter4b;
    @(posedge sclk_in) disable iff (cs_n_in || !rst_n_in)
      (ph == flash_cmd_pkg::ST_DOUT && rel_addr == 24'h00006F) |-> out_byte_reg == 8'h80;
  endproperty
  a_enter4b: assert property (p_enter4b) else $error("entry field wrong");
  property p_exit4b;
    @(posedge sclk_in) disable iff (cs_n_in || !rst_n_in)
      (ph == flash_cmd_pkg::ST_DOUT && rel_addr == 24'h00006E) |-> out_byte_reg == 8'hC0;
  endproperty
  a_exit4b: assert property (p_exit4b) else $error("exit field wrong");
  property p_rst_pair;
    @(posedge sclk_in) disable iff (!rst_n_in)
      $changed(rst_tgl_reg) |-> $past(sh_next[7:0]) == 8'h99 && $past(ph) == flash_cmd_pkg::ST_CMD;
  endproperty
  a_rst_pair: assert property (p_rst_pair) else $error("reset without reset opcode");
  property p_rst_en_width;
    @(posedge sclk_in) disable iff (!rst_n_in)
      $rose(rst_en_reg) |-> $past(cnt_reg) == (6'h07 >> $past(lc));
  endproperty
  a_rst_en_width: assert property (p_rst_en_width) else $error("enable decoded at wrong clock");
  property p_rst_needs_en;
    @(posedge sclk_in) disable iff (!rst_n_in)
      $changed(rst_tgl_reg) |-> $past(rst_en_reg);
  endproperty
  a_rst_needs_en: assert property (p_rst_needs_en) else $error("reset without enable");
  property p_nv_write;
    @(posedge sclk_in) disable iff (!rst_n_in)
      ($changed(wr_tgl_reg) && sr_wr_reg.nonvol) |-> $past(wel_reg) && !wel_reg;
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("nonvolatile write not enabled");
  property p_vol_write;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (wr_edge && !sr_wr_reg.nonvol) |=> vol_act_reg && status_reg == $past(sr_wr_reg.data);
  endproperty
  a_vol_write: assert property (p_vol_write) else $error("volatile copy not active");
  property p_status_src;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      !vol_act_reg |-> status_reg == nv_reg;
  endproperty
  a_status_src: assert property (p_status_src) else $error("status not from stored copy");
  property p_mode_zero_exit;
    @(posedge sclk_in) disable iff (!rst_n_in)
      (ph == flash_cmd_pkg::ST_MODE && last && sh_next[7:0] == 8'h00) |=> !cont_reg;
  endproperty
  a_mode_zero_exit: assert property (p_mode_zero_exit) else $error("mode zero kept continuous");
  property p_ones_exit;
    @(posedge sclk_in) disable iff (!rst_n_in)
      (ph == flash_cmd_pkg::ST_MODE && last && sh_next == 32'hFFFFFFFF) |=> !cont_reg;
  endproperty
  a_ones_exit: assert property (p_ones_exit) else $error("all ones kept continuous");

  c_soft_reset: cover property (@(posedge core_clk_in) soft_reg);
  c_vol_active: cover property (@(posedge core_clk_in) $rose(vol_act_reg));
  c_cont_entry: cover property (@(posedge sclk_in) $rose(cont_reg));
  c_dw16_out: cover property (@(posedge sclk_in) ph == flash_cmd_pkg::ST_DOUT && rel_addr == 24'h00006C);
endmodule // flash_cmd_ctrl

// ===== spi_host_model.sv
// host side serial flash controller model: frames, byte shifting, readback
// assumes the bench resolves each data line from the device's output enable
module spi_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] io_out,
  input wire logic [3:0] io_wire_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io_out = 4'h0;
  end
  // one link clock of 32 ns, sample on rising edge
  task automatic tick(input logic [3:0] v, output logic [3:0] s);
    io_out = v;
    #16;
    sclk_out = 1'b1;
    s = io_wire_in;
    #16;
    sclk_out = 1'b0;
  endtask
  // clocks with chip select high, for mode sync
  task automatic idle(input int n);
    logic [3:0] s;
    for (int i = 0; i < n; i++) tick(~io_out, s);
  endtask
  // msb first on 1, 2 or 4 lines
  task automatic send(input logic [7:0] b, input int lanes);
    logic [3:0] s;
    logic [7:0] sh;
    sh = b;
    for (int i = 0; i < 8 / lanes; i++) begin
      case (lanes)
        1: tick({~io_out[3:1], sh[7]}, s);
        2: tick({~io_out[3:2], sh[7:6]}, s);
        default: tick(sh[7:4], s);
      endcase
      sh = sh << lanes;
    end
  endtask
  // released lines show the inverse of the last value
  task automatic recv(input int lanes, output logic [7:0] b);
    logic [3:0] s;
    b = 8'h00;
    for (int i = 0; i < 8 / lanes; i++) begin
      tick(~io_out, s);
      case (lanes)
        1: b = {b[6:0], s[1]};
        2: b = {b[5:0], s[1:0]};
        default: b = {b[3:0], s};
      endcase
    end
  endtask
  task automatic open_frame();
    cs_n_out = 1'b0;
    #8;
  endtask
  task automatic close_frame();
    #8;
    cs_n_out = 1'b1;
    #40;
  endtask
  task automatic frame(input logic [7:0] b, input int lanes);
    open_frame();
    send(b, lanes);
    close_frame();
  endtask
endmodule // spi_host_model

// ===== tb_flash_reset_and_sr_write_commands.sv
// self-checking bench for the flash command logic
// assumes spi_host_model drives the link; core clock 100 MHz
module tb_flash_reset_and_sr_write_commands;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] line_mode = flash_cmd_pkg::LINES_1;
  logic sclk;
  logic cs_n;
  logic [3:0] h_io;
  logic [3:0] d_io;
  logic [3:0] d_oe;
  logic [3:0] io_wire;
  logic [7:0] status1;
  logic vol_active;
  logic soft_reset;
  int bad_count = 0;
  int n_tests = 0;
  int resets = 0;
  assign io_wire = (d_oe & d_io) | (~d_oe & h_io);
  flash_cmd_ctrl dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .io_in(io_wire), .line_mode_in(line_mode), .io_out(d_io), .io_oe_out(d_oe), .status1_out(status1),
    .vol_active_out(vol_active), .soft_reset_out(soft_reset));
  spi_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .io_out(h_io), .io_wire_in(io_wire));
  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    if (soft_reset === 1'b1) resets <= resets + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic set_mode(input logic [1:0] m);
    @(negedge core_clk_in);
    line_mode = m;
    host.idle(3);
  endtask
  task automatic wrsr(input logic [7:0] en, input logic [7:0] v);
    host.frame(en, 1);
    host.open_frame();
    host.send(flash_cmd_pkg::OP_WRSR, 1);
    host.send(v, 1);
    host.close_frame();
    repeat (10) @(negedge core_clk_in);
  endtask
  task automatic reset_pair(input int lanes, input int exp);
    int r0;
    r0 = resets;
    host.frame(flash_cmd_pkg::OP_RST_EN, lanes);
    host.frame(flash_cmd_pkg::OP_RST, lanes);
    repeat (12) @(negedge core_clk_in);
    check(resets - r0, exp);
  endtask
  task automatic t_reset();
    check({status1, vol_active, soft_reset, d_oe}, {flash_cmd_pkg::SR1_RESET, 6'h00});
    $display("test reset values done");
  endtask
  task automatic t_soft();
    set_mode(flash_cmd_pkg::LINES_2);
    reset_pair(2, 1);
    set_mode(flash_cmd_pkg::LINES_4);
    reset_pair(4, 1);
    set_mode(flash_cmd_pkg::LINES_1);
    reset_pair(1, 1);
    $display("test soft reset widths done");
  endtask
  task automatic t_refuse();
    int r0;
    r0 = resets;
    host.frame(flash_cmd_pkg::OP_RST, 1);
    host.frame(flash_cmd_pkg::OP_RST_EN, 1);
    host.frame(8'h00, 1);
    host.frame(flash_cmd_pkg::OP_RST, 1);
    repeat (12) @(negedge core_clk_in);
    check(resets - r0, 0);
    wrsr(8'h00, 8'h77);
    check(status1, flash_cmd_pkg::SR1_RESET);
    $display("test refused commands done");
  endtask
  task automatic t_wrsr();
    wrsr(flash_cmd_pkg::OP_WREN, 8'h5A);
    check({status1, vol_active}, {8'h5A, 1'b0});
    wrsr(flash_cmd_pkg::OP_VWREN, 8'hA5);
    check({status1, vol_active}, {8'hA5, 1'b1});
    wrsr(flash_cmd_pkg::OP_WREN, 8'h3C);
    check({status1, vol_active}, {8'hA5, 1'b1});
    $display("test status writes done");
  endtask
  task automatic t_sfdp();
    logic [7:0] b [4];
    host.open_frame();
    host.send(flash_cmd_pkg::OP_SFDP, 1);
    host.send(8'h00, 1);
    host.send(8'h00, 1);
    host.send(8'h6C, 1);
    host.send(8'h00, 1);
    for (int i = 0; i < 4; i++) host.recv(1, b[i]);
    #4;
    check(d_oe, 4'h2);
    host.close_frame();
    check({b[3], b[2], b[1], b[0]}, 32'h80C030E8);
    check(b[3], 8'h80);
    check({b[2][7:0], b[1][7:6]}, 10'h300);
    check(d_oe, 4'h0);
    $display("test discovery dword done");
  endtask
  task automatic cont_frame(input logic [7:0] a, input logic [7:0] m);
    host.open_frame();
    for (int i = 0; i < 3; i++) host.send(a, 4);
    host.send(m, 4);
    host.close_frame();
  endtask
  task automatic t_cont();
    int r0;
    for (int k = 0; k < 2; k++) begin
      r0 = resets;
      host.open_frame();
      host.send(flash_cmd_pkg::OP_QREAD, 1);
      for (int i = 0; i < 3; i++) host.send(8'h00, 4);
      host.send(8'hA0, 4);
      host.close_frame();
      cont_frame(flash_cmd_pkg::OP_RST_EN, 8'hA0);
      cont_frame(flash_cmd_pkg::OP_RST, 8'hA0);
      repeat (12) @(negedge core_clk_in);
      check(resets - r0, 0);
      // mode zero or eight all-ones clocks
      if (k == 0) cont_frame(8'h00, flash_cmd_pkg::MODE_EXIT);
      else cont_frame(8'hFF, 8'hFF);
      reset_pair(1, 1);
    end
    $display("test continuous read exit done");
  endtask
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial begin
    #3;
    fork
      host.idle(3);
      repeat (20) @(negedge core_clk_in);
    join
    rst_n_in = 1'b1;
    host.idle(3);
    t_reset();
    t_soft();
    t_refuse();
    t_wrsr();
    t_sfdp();
    t_cont();
    stop_test();
  end
endmodule // tb_flash_reset_and_sr_write_commands
